// ---- rtcc_pkg.sv ----
package rtcc_pkg;

  // ------------------------------------------------------------
  // Register offsets in configuration space.
  // ------------------------------------------------------------
  localparam logic [7:0] RTCC_RETRY_OFF = 8'h90;
  localparam logic [7:0] RTCC_CARD_OFF = 8'h91;

  // ------------------------------------------------------------
  // Reset values.
  // ------------------------------------------------------------
  localparam logic [7:0] RTCC_RETRY_RST = 8'hC0;
  localparam logic [7:0] RTCC_CARD_RST = 8'h00;

  // ------------------------------------------------------------
  // Field positions of the retry register.
  // ------------------------------------------------------------
  localparam int RTCC_HOST_EN_BIT = 7;
  localparam int RTCC_CARD_EN_BIT = 6;
  localparam int RTCC_SKB_EXP_BIT = 5;
  localparam int RTCC_SKA_EXP_BIT = 3;
  localparam int RTCC_HOST_EXP_BIT = 1;

  // ------------------------------------------------------------
  // Field positions of the card control register.
  // ------------------------------------------------------------
  localparam int RTCC_RING_BIT = 7;
  localparam int RTCC_RSVD_HI = 6;
  localparam int RTCC_RSVD_LO = 3;
  localparam int RTCC_AUDIO_BIT = 2;
  localparam int RTCC_CARD_SPEAKER_INPUT_BIT = 1;
  localparam int RTCC_IRQ_BIT = 0;

  // ------------------------------------------------------------
  // Retry time-out: the limit is a count of clock cycles.
  // ------------------------------------------------------------
  localparam int RTCC_TIMEOUT_EXP = 15;
  localparam int RTCC_CNT_W = RTCC_TIMEOUT_EXP + 1;
  localparam logic [RTCC_CNT_W-1:0] RTCC_CNT_ONE = 16'h0001;

  // Number of retry counters: host side, socket A, socket B.
  localparam int RTCC_NUM_CNT = 3;
  localparam int RTCC_CNT_HOST = 0;
  localparam int RTCC_CNT_SKA = 1;
  localparam int RTCC_CNT_SKB = 2;

endpackage

// ---- rtcc_retry_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

// One retry time-out watcher. It runs from a received retry until the same
// master request is re-issued and pulses expired once the limit is reached.
module rtcc_retry_timer #(
  parameter int LIMIT = 32768
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic enable,
  input wire logic retry_seen,
  input wire logic reissued,
  output logic expired
);

  // ------------------------------------------------------------
  // Counter state.
  // ------------------------------------------------------------
  logic running_r; // Counting toward the limit.
  logic running_nxt;
  logic [rtcc_pkg::RTCC_CNT_W-1:0] count_r; // Cycles since the retry.
  logic [rtcc_pkg::RTCC_CNT_W-1:0] count_nxt;
  logic expired_r; // One-cycle expiry pulse.
  logic expired_nxt;
  logic at_limit; // Count has reached the limit.

  assign at_limit = (count_r == rtcc_pkg::RTCC_CNT_W'(LIMIT - 1));

  // A re-issue stops the count; a new retry restarts it. Disabled, it idles,
  // so a retry seen while disabled is never timed even after re-enable.
  assign running_nxt = enable & ~reissued & (retry_seen | (running_r & ~at_limit));
  assign count_nxt = (retry_seen | ~running_r) ? '0 : count_r + rtcc_pkg::RTCC_CNT_ONE;
  assign expired_nxt = enable & running_r & at_limit & ~reissued & ~retry_seen;

  // Registers of the watcher.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      running_r <= 1'b0;
      count_r <= '0;
      expired_r <= 1'b0;
    end else begin
      running_r <= running_nxt;
      count_r <= count_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign expired = expired_r;

endmodule

`default_nettype wire

// ---- rtcc_regs.sv ----
// What this block does
// - Set expired flag after unreissued retry timeout
// - Expired flags clear on write one only
// - Bit 7 enables host retry counter
// - Bit 6 enables card retry counter
// - Bit 5 flags socket B retry expiry
// - Bit 3 flags socket A retry expiry
// - Bit 1 flags host-side retry expiry
// - Retry bits 4, 2, 0 read zero
// - Sticky bits reset only by global reset
// - Card bit 7 enables ring output pin
// - Card bit 2 zero routes audio PWM
// - Both functions clear bit 2: function 0 audio routed
// - Card bit 1 passes speaker to output
// - Speaker output is XOR of sockets
// - Speaker pin driven when either enable set
// - Card bit 0 set on socket interrupt
`timescale 1ns/1ps
`default_nettype none

module rtcc_regs (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic GLOBAL_RESET_N,
  input wire logic CFG_WR,
  input wire logic CFG_FUNC,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  input wire logic HOST_RETRY,
  input wire logic HOST_REISSUE,
  input wire logic SKA_RETRY,
  input wire logic SKA_REISSUE,
  input wire logic SKB_RETRY,
  input wire logic SKB_REISSUE,
  input wire logic [1:0] CARD_FUNCTIONAL_IRQ,
  input wire logic [1:0] CARD_SPEAKER_INPUT,
  input wire logic [1:0] CARD_AUDIO_SIGNAL,
  input wire logic RING_REQUEST,
  output logic RING_INDICATE_OUTPUT,
  output logic RING_INDICATE_OUTPUT_OE_N,
  output logic CARD_AUDIO_PWM,
  output logic CARD_AUDIO_PWM_VALID,
  output logic SPEAKER_OUTPUT_PIN,
  output logic SPEAKER_OUTPUT_PIN_OE_N
);

  // ------------------------------------------------------------
  // Synchronisers for pins that come from the sockets.
  // ------------------------------------------------------------
  // Layout: [1:0] irq, [3:2] speaker, [5:4] audio, [6] ring.
  localparam int SYNC_W = 7;
  logic [SYNC_W-1:0] pin_raw; // Raw pin levels.
  logic [SYNC_W-1:0] sync1_r; // First stage, read only by the second.
  logic [SYNC_W-1:0] sync2_r; // Stable sampled levels.
  logic [1:0] irq_s; // Synchronised socket interrupt levels.
  logic [1:0] irq_prev_r; // Previous interrupt levels for edge detection.
  logic [1:0] card_speaker_input_s; // Synchronised speaker levels.
  logic [1:0] audio_s; // Synchronised audio levels.
  logic ring_s; // Synchronised ring request.

  assign pin_raw = {RING_REQUEST, CARD_AUDIO_SIGNAL, CARD_SPEAKER_INPUT, CARD_FUNCTIONAL_IRQ};
  assign irq_s = sync2_r[1:0];
  assign card_speaker_input_s = sync2_r[3:2];
  assign audio_s = sync2_r[5:4];
  assign ring_s = sync2_r[6];

  // Two flip-flops before any logic reads the pins.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_r <= '0;
      sync2_r <= '0;
      irq_prev_r <= '0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      irq_prev_r <= irq_s;
    end
  end

  // ------------------------------------------------------------
  // Write decode.
  // ------------------------------------------------------------
  logic wr_retry; // Write to the shared retry register.
  logic wr_card; // Write to a card control register.
  logic wr_card_f0; // Write reaching shared card bits through function 0.

  // Shared bits are only reachable from function 0; function 1 writes to
  // them are dropped, which protects against software breaking that convention.
  assign wr_retry = CFG_WR & (CFG_ADDR == rtcc_pkg::RTCC_RETRY_OFF) & ~CFG_FUNC;
  assign wr_card = CFG_WR & (CFG_ADDR == rtcc_pkg::RTCC_CARD_OFF);
  assign wr_card_f0 = wr_card & ~CFG_FUNC;

  // ------------------------------------------------------------
  // Retry time-out counters.
  // ------------------------------------------------------------
  logic host_en_r; // Host-side counter enable.
  logic card_en_r; // Card-side counter enable.
  logic [rtcc_pkg::RTCC_NUM_CNT-1:0] cnt_en; // Enable per counter.
  logic [rtcc_pkg::RTCC_NUM_CNT-1:0] cnt_retry; // Retry seen per counter.
  logic [rtcc_pkg::RTCC_NUM_CNT-1:0] cnt_reissue; // Re-issue per counter.
  logic [rtcc_pkg::RTCC_NUM_CNT-1:0] cnt_exp; // Expiry pulse per counter.

  assign cnt_en = {card_en_r, card_en_r, host_en_r};
  assign cnt_retry = {SKB_RETRY, SKA_RETRY, HOST_RETRY};
  assign cnt_reissue = {SKB_REISSUE, SKA_REISSUE, HOST_REISSUE};

  // One watcher per master path.
  genvar gi;
  generate
    for (gi = 0; gi < rtcc_pkg::RTCC_NUM_CNT; gi++) begin : g_timer
      rtcc_retry_timer #(
        .LIMIT(1 << rtcc_pkg::RTCC_TIMEOUT_EXP)
      ) u_timer (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .enable(cnt_en[gi]),
        .retry_seen(cnt_retry[gi]),
        .reissued(cnt_reissue[gi]),
        .expired(cnt_exp[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Sticky flags: set wins over a simultaneous write-one clear.
  // ------------------------------------------------------------
  function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
    sticky_next = set | (cur & ~clr);
  endfunction

  logic host_exp_r; // Host-side target retry expired.
  logic ska_exp_r; // Socket A retry expired.
  logic skb_exp_r; // Socket B retry expired.
  logic host_exp_nxt;
  logic ska_exp_nxt;
  logic skb_exp_nxt;
  logic host_en_nxt;
  logic card_en_nxt;

  assign host_exp_nxt = sticky_next(host_exp_r, cnt_exp[rtcc_pkg::RTCC_CNT_HOST],
    wr_retry & CFG_WDATA[rtcc_pkg::RTCC_HOST_EXP_BIT]);
  assign ska_exp_nxt = sticky_next(ska_exp_r, cnt_exp[rtcc_pkg::RTCC_CNT_SKA],
    wr_retry & CFG_WDATA[rtcc_pkg::RTCC_SKA_EXP_BIT]);
  assign skb_exp_nxt = sticky_next(skb_exp_r, cnt_exp[rtcc_pkg::RTCC_CNT_SKB],
    wr_retry & CFG_WDATA[rtcc_pkg::RTCC_SKB_EXP_BIT]);
  assign host_en_nxt = wr_retry ? CFG_WDATA[rtcc_pkg::RTCC_HOST_EN_BIT] : host_en_r;
  assign card_en_nxt = wr_retry ? CFG_WDATA[rtcc_pkg::RTCC_CARD_EN_BIT] : card_en_r;

  // ------------------------------------------------------------
  // Card control fields.
  // ------------------------------------------------------------
  logic ring_en_r; // Shared ring output enable.
  logic ring_en_nxt;
  logic [3:0] rsvd_r; // Reserved storage, bits 6 to 3.
  logic [3:0] rsvd_nxt;
  logic [1:0] audio_dis_r; // Per-function audio route disable.
  logic [1:0] audio_dis_nxt;
  logic [1:0] card_speaker_input_en_r; // Per-function speaker enable.
  logic [1:0] card_speaker_input_en_nxt;
  logic [1:0] irq_flag_r; // Per-socket functional interrupt flag.
  logic [1:0] irq_flag_nxt;
  logic [1:0] irq_rise; // Interrupt asserted this cycle.
  logic [1:0] func_sel; // One-hot function of the current access.

  assign func_sel = {CFG_FUNC, ~CFG_FUNC};
  assign irq_rise = irq_s & ~irq_prev_r;
  assign ring_en_nxt = wr_card_f0 ? CFG_WDATA[rtcc_pkg::RTCC_RING_BIT] : ring_en_r;
  // Reserved bits hold what was written; software keeps them as read.
  assign rsvd_nxt = wr_card_f0 ?
    CFG_WDATA[rtcc_pkg::RTCC_RSVD_HI:rtcc_pkg::RTCC_RSVD_LO] : rsvd_r;

  // Per-function fields, one copy per socket.
  generate
    for (gi = 0; gi < 2; gi++) begin : g_func
      assign audio_dis_nxt[gi] = (wr_card & func_sel[gi]) ?
        CFG_WDATA[rtcc_pkg::RTCC_AUDIO_BIT] : audio_dis_r[gi];
      assign card_speaker_input_en_nxt[gi] = (wr_card & func_sel[gi]) ?
        CFG_WDATA[rtcc_pkg::RTCC_CARD_SPEAKER_INPUT_BIT] : card_speaker_input_en_r[gi];
      assign irq_flag_nxt[gi] = sticky_next(irq_flag_r[gi], irq_rise[gi],
        wr_card & func_sel[gi] & CFG_WDATA[rtcc_pkg::RTCC_IRQ_BIT]);
    end
  endgenerate

  // ------------------------------------------------------------
  // Sticky registers, cleared only by global reset.
  // ------------------------------------------------------------
  // The core reset leaves them alone, so settings survive an ordinary bus reset.
  // The limitation is that the global reset must be pulsed at power-up.
  logic sticky_rst_n; // Reset for the sticky registers.
  logic plain_rst_n; // Reset for the reserved card bits, which are not sticky.
  assign sticky_rst_n = GLOBAL_RESET_N;
  assign plain_rst_n = ARST_N & GLOBAL_RESET_N;

  always_ff @(posedge CLK or negedge sticky_rst_n) begin
    if (!sticky_rst_n) begin
      host_en_r <= rtcc_pkg::RTCC_RETRY_RST[rtcc_pkg::RTCC_HOST_EN_BIT];
      card_en_r <= rtcc_pkg::RTCC_RETRY_RST[rtcc_pkg::RTCC_CARD_EN_BIT];
      host_exp_r <= 1'b0;
      ska_exp_r <= 1'b0;
      skb_exp_r <= 1'b0;
      ring_en_r <= rtcc_pkg::RTCC_CARD_RST[rtcc_pkg::RTCC_RING_BIT];
      audio_dis_r <= '0;
      card_speaker_input_en_r <= '0;
      irq_flag_r <= '0;
    end else begin
      host_en_r <= host_en_nxt;
      card_en_r <= card_en_nxt;
      host_exp_r <= host_exp_nxt;
      ska_exp_r <= ska_exp_nxt;
      skb_exp_r <= skb_exp_nxt;
      ring_en_r <= ring_en_nxt;
      audio_dis_r <= audio_dis_nxt;
      card_speaker_input_en_r <= card_speaker_input_en_nxt;
      irq_flag_r <= irq_flag_nxt;
    end
  end

  // Reserved card bits are not sticky, so either reset restores them.
  always_ff @(posedge CLK or negedge plain_rst_n) begin
    if (!plain_rst_n) begin
      rsvd_r <= rtcc_pkg::RTCC_CARD_RST[rtcc_pkg::RTCC_RSVD_HI:rtcc_pkg::RTCC_RSVD_LO];
    end else begin
      rsvd_r <= rsvd_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read path.
  // ------------------------------------------------------------
  logic [7:0] retry_view; // Retry register as read.
  logic [7:0] card_view; // Card control as read by the addressed function.
  logic [7:0] rdata_nxt;
  logic sel_f; // Index of the addressed function.

  assign sel_f = CFG_FUNC;
  // Reserved bits 4, 2 and 0 are tied low.
  assign retry_view = {host_en_r, card_en_r, skb_exp_r, 1'b0,
    ska_exp_r, 1'b0, host_exp_r, 1'b0};
  assign card_view = {ring_en_r, rsvd_r, audio_dis_r[sel_f], card_speaker_input_en_r[sel_f],
    irq_flag_r[sel_f]};
  assign rdata_nxt = (CFG_ADDR == rtcc_pkg::RTCC_RETRY_OFF) ? retry_view :
    (CFG_ADDR == rtcc_pkg::RTCC_CARD_OFF) ? card_view : 8'h00;

  // ------------------------------------------------------------
  // Pin outputs.
  // ------------------------------------------------------------
  logic audio_on; // Some function routes card audio.
  logic audio_sel; // Audio level of the chosen socket.
  logic card_speaker_input_on; // Speaker pin drives.
  logic card_speaker_input_mix; // Exclusive-OR of both sockets' speakers.

  // Function 0 has priority when both route audio.
  assign audio_on = ~audio_dis_r[0] | ~audio_dis_r[1];
  assign audio_sel = ~audio_dis_r[0] ? audio_s[0] : audio_s[1];
  assign card_speaker_input_mix = card_speaker_input_s[0] ^ card_speaker_input_s[1];
  assign card_speaker_input_on = card_speaker_input_en_r[0] | card_speaker_input_en_r[1];

  logic ring_q_r; // Ring output level.
  logic ring_oe_n_r; // Ring output enable, low drives.
  logic aud_q_r; // Audio PWM level.
  logic aud_v_r; // Audio routed to the pin.
  logic spk_q_r; // Speaker level.
  logic spk_oe_n_r; // Speaker enable, low drives.
  logic [7:0] rdata_r; // Registered read data.

  // Outputs are registered so the pins see no decode glitches.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ring_q_r <= 1'b0;
      ring_oe_n_r <= 1'b1;
      aud_q_r <= 1'b0;
      aud_v_r <= 1'b0;
      spk_q_r <= 1'b0;
      spk_oe_n_r <= 1'b1;
      rdata_r <= 8'h00;
    end else begin
      ring_q_r <= ring_en_r & ring_s;
      ring_oe_n_r <= ~ring_en_r;
      aud_q_r <= audio_on & audio_sel;
      aud_v_r <= audio_on;
      spk_q_r <= card_speaker_input_on & card_speaker_input_mix;
      spk_oe_n_r <= ~card_speaker_input_on;
      rdata_r <= rdata_nxt;
    end
  end

  assign CFG_RDATA = rdata_r;
  assign RING_INDICATE_OUTPUT = ring_q_r;
  assign RING_INDICATE_OUTPUT_OE_N = ring_oe_n_r;
  assign CARD_AUDIO_PWM = aud_q_r;
  assign CARD_AUDIO_PWM_VALID = aud_v_r;
  assign SPEAKER_OUTPUT_PIN = spk_q_r;
  assign SPEAKER_OUTPUT_PIN_OE_N = spk_oe_n_r;

endmodule

`default_nettype wire

// ---- rtcc_regs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Port checker for the retry and card control registers.
// ------------------------------------------------------------
module rtcc_regs_monitor (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic GLOBAL_RESET_N,
  input wire logic CFG_WR,
  input wire logic CFG_FUNC,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  input wire logic [7:0] CFG_RDATA,
  input wire logic [1:0] CARD_SPEAKER_INPUT,
  input wire logic RING_REQUEST,
  input wire logic RING_INDICATE_OUTPUT,
  input wire logic RING_INDICATE_OUTPUT_OE_N,
  input wire logic CARD_AUDIO_PWM_VALID,
  input wire logic SPEAKER_OUTPUT_PIN,
  input wire logic SPEAKER_OUTPUT_PIN_OE_N
);
  default clocking cb @(posedge CLK); endclocking
  // Core reset clears the pin and read registers, global reset the sticky ones, so every check pauses under both.
  default disable iff (!ARST_N || !GLOBAL_RESET_N);

  // Function 0 writes; only these may touch the shared bits.
  wire card_wr0 = CFG_WR && !CFG_FUNC && (CFG_ADDR == rtcc_pkg::RTCC_CARD_OFF);
  wire retry_wr0 = CFG_WR && !CFG_FUNC && (CFG_ADDR == rtcc_pkg::RTCC_RETRY_OFF);

  AST_RSVD_ZERO: assert property (
    $past(CFG_ADDR) == rtcc_pkg::RTCC_RETRY_OFF |-> !CFG_RDATA[4] && !CFG_RDATA[2] && !CFG_RDATA[0]
  ) else $error("Reserved retry bit read as one.");
  AST_RETRY_EN_WRITE: assert property (
    retry_wr0 ##1 (CFG_ADDR == rtcc_pkg::RTCC_RETRY_OFF) |=> CFG_RDATA[7:6] == $past(CFG_WDATA[7:6], 2)
  ) else $error("Counter enable bits did not take the written value.");
  AST_RING_OE_WRITE: assert property (
    card_wr0 |-> ##2 (RING_INDICATE_OUTPUT_OE_N == !$past(CFG_WDATA[7], 2))
  ) else $error("Ring output enable does not follow its bit.");
  AST_RING_GATED: assert property (
    RING_INDICATE_OUTPUT_OE_N |-> !RING_INDICATE_OUTPUT
  ) else $error("Ring output active while not driven.");
  // The pins pass a two-flop synchroniser, so only settled levels count.
  AST_RING_FOLLOW: assert property (
    ($stable(RING_REQUEST) [*5]) ##0 !RING_INDICATE_OUTPUT_OE_N |-> RING_INDICATE_OUTPUT == RING_REQUEST
  ) else $error("Ring output differs from the ring level.");
  AST_CARD_SPEAKER_INPUT_OE_WRITE: assert property (
    card_wr0 && CFG_WDATA[1] |-> ##2 !SPEAKER_OUTPUT_PIN_OE_N
  ) else $error("Speaker pin not driven after enable.");
  AST_CARD_SPEAKER_INPUT_GATED: assert property (
    SPEAKER_OUTPUT_PIN_OE_N |-> !SPEAKER_OUTPUT_PIN
  ) else $error("Speaker pin active while not driven.");
  AST_CARD_SPEAKER_INPUT_XOR: assert property (
    ($stable(CARD_SPEAKER_INPUT) [*5]) ##0 !SPEAKER_OUTPUT_PIN_OE_N
      |-> SPEAKER_OUTPUT_PIN == (CARD_SPEAKER_INPUT[0] ^ CARD_SPEAKER_INPUT[1])
  ) else $error("Speaker pin is not the exclusive-or of the sockets.");
  AST_AUDIO_ROUTE: assert property (
    card_wr0 && !CFG_WDATA[2] |-> ##2 CARD_AUDIO_PWM_VALID
  ) else $error("Card audio not routed after clearing its bit.");

  // Main scenarios seen at least once.
  cover property (retry_wr0);
  cover property (!SPEAKER_OUTPUT_PIN_OE_N && SPEAKER_OUTPUT_PIN);
  cover property (CARD_AUDIO_PWM_VALID);
endmodule

bind rtcc_regs rtcc_regs_monitor i_rtcc_regs_monitor (
  .CLK, .ARST_N, .GLOBAL_RESET_N, .CFG_WR, .CFG_FUNC, .CFG_ADDR, .CFG_WDATA, .CFG_RDATA,
  .CARD_SPEAKER_INPUT, .RING_REQUEST, .RING_INDICATE_OUTPUT, .RING_INDICATE_OUTPUT_OE_N,
  .CARD_AUDIO_PWM_VALID, .SPEAKER_OUTPUT_PIN, .SPEAKER_OUTPUT_PIN_OE_N
);

`default_nettype wire

// ---- rtcc_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Far side: bus master events and socket pin levels.
// ------------------------------------------------------------
// Everything leaves a flop, as a real master and card would drive it.
module rtcc_far_end (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [5:0] kick,
  input wire logic [1:0] irq_lvl,
  input wire logic [1:0] spk_lvl,
  input wire logic [1:0] aud_lvl,
  input wire logic ring_lvl,
  output logic [2:0] retry_p,
  output logic [2:0] reissue_p,
  output logic [1:0] irq_pin,
  output logic [1:0] spk_pin,
  output logic [1:0] aud_pin,
  output logic ring_pin
);
  // Kick bits 2..0 are retries, 5..3 re-issues; each lasts one cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {reissue_p, retry_p} <= 6'h00;
      {irq_pin, spk_pin, aud_pin, ring_pin} <= 7'h00;
    end else begin
      {reissue_p, retry_p} <= kick;
      {irq_pin, spk_pin, aud_pin, ring_pin} <= {irq_lvl, spk_lvl, aud_lvl, ring_lvl};
    end
  end
endmodule

`default_nettype wire

// ---- rtcc_regs_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module rtcc_regs_bench;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic GLOBAL_RESET_N = 1'b0;
  logic CFG_WR = 1'b0;
  logic CFG_FUNC = 1'b0;
  logic [7:0] CFG_ADDR = 8'h00;
  logic [7:0] CFG_WDATA = 8'h00;
  logic [5:0] kick = 6'h00;
  logic [1:0] irq_lvl = 2'h0;
  logic [1:0] spk_lvl = 2'h0;
  logic [1:0] aud_lvl = 2'h0;
  logic ring_lvl = 1'b0;
  logic [7:0] rdata;
  logic [2:0] retry_p;
  logic [2:0] reissue_p;
  logic [1:0] irq_pin;
  logic [1:0] spk_pin;
  logic [1:0] aud_pin;
  logic ring_pin;
  logic ring_o, ring_oe_n, pwm, pwm_ok, spk_o, spk_oe_n;
  int mismatches = 0;
  int tests_run = 0;

  initial begin
    forever #10 CLK = ~CLK;
  end

  rtcc_far_end i_rtcc_far_end (.clk(CLK), .arst_n(ARST_N), .kick(kick), .irq_lvl(irq_lvl),
    .spk_lvl(spk_lvl), .aud_lvl(aud_lvl), .ring_lvl(ring_lvl), .retry_p(retry_p),
    .reissue_p(reissue_p), .irq_pin(irq_pin), .spk_pin(spk_pin), .aud_pin(aud_pin),
    .ring_pin(ring_pin));

  rtcc_regs i_rtcc_regs (.CLK(CLK), .ARST_N(ARST_N), .GLOBAL_RESET_N(GLOBAL_RESET_N),
    .CFG_WR(CFG_WR), .CFG_FUNC(CFG_FUNC), .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA),
    .CFG_RDATA(rdata), .HOST_RETRY(retry_p[0]), .HOST_REISSUE(reissue_p[0]),
    .SKA_RETRY(retry_p[1]), .SKA_REISSUE(reissue_p[1]), .SKB_RETRY(retry_p[2]),
    .SKB_REISSUE(reissue_p[2]), .CARD_FUNCTIONAL_IRQ(irq_pin), .CARD_SPEAKER_INPUT(spk_pin),
    .CARD_AUDIO_SIGNAL(aud_pin), .RING_REQUEST(ring_pin), .RING_INDICATE_OUTPUT(ring_o),
    .RING_INDICATE_OUTPUT_OE_N(ring_oe_n), .CARD_AUDIO_PWM(pwm), .CARD_AUDIO_PWM_VALID(pwm_ok),
    .SPEAKER_OUTPUT_PIN(spk_o), .SPEAKER_OUTPUT_PIN_OE_N(spk_oe_n));

  // ------------------------------------------------------------
  // Access and compare tasks.
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe; the address is left standing afterwards.
  task automatic cfg_wr(input logic f, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    CFG_WR <= 1'b1;
    CFG_FUNC <= f;
    CFG_ADDR <= a;
    CFG_WDATA <= d;
    @(posedge CLK);
    CFG_WR <= 1'b0;
  endtask

  // Read data is registered, so it is looked at two edges later.
  task automatic cfg_rd(input logic f, input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    CFG_FUNC <= f;
    CFG_ADDR <= a;
    repeat (2) @(posedge CLK);
    #1;
    check(rdata, exp);
  endtask

  task automatic kick_it(input logic [5:0] k);
    @(posedge CLK);
    kick <= k;
    @(posedge CLK);
    kick <= 6'h00;
  endtask

  // Pins cross a synchroniser plus an output flop; six edges is ample.
  task automatic pins(input logic [7:0] exp);
    repeat (6) @(posedge CLK);
    #1;
    check({ring_o, ring_oe_n, spk_o, spk_oe_n, pwm & pwm_ok, pwm_ok, 2'b00}, exp);
  endtask

  task automatic close_out();
    $display("Totals: %0d compares, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge CLK);
    ARST_N <= 1'b1;
    GLOBAL_RESET_N <= 1'b1;
    cfg_rd(1'b0, rtcc_pkg::RTCC_RETRY_OFF, rtcc_pkg::RTCC_RETRY_RST);
    cfg_rd(1'b0, rtcc_pkg::RTCC_CARD_OFF, rtcc_pkg::RTCC_CARD_RST);
    cfg_rd(1'b0, 8'h92, 8'h00);
    $display("Test reset values finished.");
    // Host counter off; socket B is re-issued in time, socket A is not.
    cfg_wr(1'b0, 8'h90, 8'h40);
    kick_it(6'h07);
    repeat (100) @(posedge CLK);
    kick_it(6'h20);
    repeat (32800) @(posedge CLK);
    cfg_rd(1'b0, 8'h90, 8'h48);
    cfg_wr(1'b1, 8'h90, 8'hFF);
    cfg_rd(1'b1, 8'h90, 8'h48);
    cfg_wr(1'b0, 8'h90, 8'hC8);
    cfg_rd(1'b0, 8'h90, 8'hC0);
    // Host and socket B time out; nothing may show before the limit.
    kick_it(6'h05);
    repeat (32700) @(posedge CLK);
    cfg_rd(1'b0, 8'h90, 8'hC0);
    repeat (100) @(posedge CLK);
    cfg_rd(1'b0, 8'h90, 8'hE2);
    cfg_wr(1'b0, 8'h90, 8'hE0);
    cfg_rd(1'b0, 8'h90, 8'hC2);
    $display("Test retry time-out finished.");
    // Both functions route audio, so socket 0 must win.
    ring_lvl <= 1'b1;
    spk_lvl <= 2'b01;
    aud_lvl <= 2'b10;
    cfg_wr(1'b0, 8'h91, 8'h82);
    pins(8'hA4);
    spk_lvl <= 2'b11;
    cfg_wr(1'b0, 8'h91, 8'h86);
    pins(8'h8C);
    cfg_wr(1'b0, 8'h91, 8'h04);
    cfg_wr(1'b1, 8'h91, 8'h86);
    pins(8'h40);
    $display("Test card pins finished.");
    irq_lvl <= 2'b10;
    repeat (6) @(posedge CLK);
    cfg_rd(1'b1, 8'h91, 8'h07);
    cfg_rd(1'b0, 8'h91, 8'h04);
    irq_lvl <= 2'b00;
    cfg_wr(1'b1, 8'h91, 8'h07);
    cfg_rd(1'b1, 8'h91, 8'h06);
    $display("Test card interrupt finished.");
    // A core reset in mid-run must leave the retry bits and function 1's card bits as they were.
    @(posedge CLK);
    ARST_N <= 1'b0;
    @(posedge CLK);
    ARST_N <= 1'b1;
    cfg_rd(1'b0, 8'h90, 8'hC2);
    cfg_rd(1'b1, 8'h91, 8'h06);
    $display("Test core reset finished.");
    @(posedge CLK);
    GLOBAL_RESET_N <= 1'b0;
    @(posedge CLK);
    GLOBAL_RESET_N <= 1'b1;
    cfg_rd(1'b0, 8'h90, rtcc_pkg::RTCC_RETRY_RST);
    cfg_rd(1'b1, 8'h91, rtcc_pkg::RTCC_CARD_RST);
    $display("Test global reset finished.");
    close_out();
  end

  // Two long time-outs of some 33000 cycles each, plus a little margin.
  initial begin
    repeat (80000) @(posedge CLK);
    mismatches++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    close_out();
  end
endmodule

`default_nettype wire
